// ===== hw/fbap_panel.sv
// Overview of operation
// - Power-up: normal mode, both digits steady
// - Double click enters high-digit edit, high blinks
// - Short press increments the blinking digit
// - Long press on high digit moves to low
// - Long press on low digit saves, returns normal
// - Ten idle seconds abandon edit, keep old address
// - Link indicator blinks during fieldbus exchange
// - Fault indicator lit while fieldbus failed
// - Receive indicator blinks while serial bytes arrive
// - Transmit indicator blinks while serial bytes leave
// - Drive bus direction output on connector
`timescale 1ns/1ns
`default_nettype none

module fbap_panel import fbap_pkg::*; #(
  parameter logic [TICK_W-1:0] TICK_CYC = TICK_W'(TICK_CYC_DEF),
  parameter logic [CNT_W-1:0] LONG_TICKS = CNT_W'(LONG_TICKS_DEF),
  parameter logic [CNT_W-1:0] IDLE_TICKS = CNT_W'(IDLE_TICKS_DEF),
  parameter logic [CNT_W-1:0] DEB_TICKS = CNT_W'(DEB_TICKS_DEF),
  parameter logic [CNT_W-1:0] DBL_TICKS = CNT_W'(DBL_TICKS_DEF),
  parameter logic [CNT_W-1:0] BLINK_TICKS = CNT_W'(BLINK_TICKS_DEF),
  parameter logic [CNT_W-1:0] ACT_TICKS = CNT_W'(ACT_TICKS_DEF)
) (
  input wire logic CLK_SYS, // 250 MHz system clock
  input wire logic RESET, // Synchronous reset, high
  input wire logic BUTTON_N, // Push button pin, low when pressed
  input wire logic LINK_ACTIVE, // Fieldbus exchange strobe
  input wire logic BUS_FAIL, // Fieldbus communication failed
  input wire logic SER_RX_ACT, // Serial byte received strobe
  input wire logic SER_TX_ACT, // Serial byte sent strobe
  input wire logic BUS_TX_EN, // Fieldbus transmitter enabled
  input wire logic [7:0] SAVED_ADDR, // Retained address, two BCD digits
  output logic [3:0] DISP_HI, // High digit value
  output logic [3:0] DISP_LO, // Low digit value
  output logic DISP_HI_EN, // High digit lit
  output logic DISP_LO_EN, // Low digit lit
  output logic [7:0] STATION_ADDR, // Effective station address, BCD
  output logic ADDR_SAVE, // Pulse: store STATION_ADDR
  output logic LED_LINK, // Link activity indicator
  output logic LED_FAULT, // Bus fault indicator
  output logic LED_RX, // Serial receive indicator
  output logic LED_TX, // Serial transmit indicator
  output logic BUS_DIR // Bus direction on connector
);

  typedef struct packed {
    logic btn_meta;
    logic btn_sync;
    logic [TICK_W-1:0] div;
    logic tick;
    fbap_mode_t mode;
    logic loaded;
    logic [3:0] addr_hi;
    logic [3:0] addr_lo;
    logic [3:0] edit_hi;
    logic [3:0] edit_lo;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] blink_cnt;
    logic blink;
    logic [ACT_N-1:0][CNT_W-1:0] act_hold;
    logic [3:0] disp_hi;
    logic [3:0] disp_lo;
    logic disp_hi_en;
    logic disp_lo_en;
    logic save;
    logic led_link;
    logic led_fault;
    logic led_rx;
    logic led_tx;
    logic dir;
  } fbap_state_t;

  fbap_state_t s;
  fbap_state_t n;
  logic [ACT_N-1:0] act;
  fbap_btn_if bi ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] digit_inc(input logic [3:0] d);
    return (d >= DIGIT_MAX) ? DIGIT_RST : d + 4'h1;
  endfunction : digit_inc

  // A corrupt stored nibble falls back to zero rather than showing junk
  function automatic logic [3:0] digit_clamp(input logic [3:0] d);
    return (d > DIGIT_MAX) ? DIGIT_RST : d;
  endfunction : digit_clamp

  // ----------------------------------------------------------------
  // Button classifier
  // ----------------------------------------------------------------
  assign bi.tick = s.tick;
  assign bi.level = s.btn_sync;

  fbap_button #(
    .DEB_TICKS(DEB_TICKS),
    .LONG_TICKS(LONG_TICKS),
    .DBL_TICKS(DBL_TICKS)
  ) u_button (
    .clk(CLK_SYS),
    .rst(RESET),
    .bi(bi.btn)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.save = 1'b0;
    n.tick = 1'b0;
    act = '0;
    act[ACT_LINK] = LINK_ACTIVE;
    act[ACT_RX] = SER_RX_ACT;
    act[ACT_TX] = SER_TX_ACT;

    // Pin synchroniser, pressed reads as high
    n.btn_meta = ~BUTTON_N;
    n.btn_sync = s.btn_meta;

    // Millisecond tick
    if (s.div >= TICK_CYC - 1'b1) begin
      n.div = '0;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 1'b1;
    end

    // Shared blink phase for digits and indicators
    if (s.tick) begin
      if (s.blink_cnt >= BLINK_TICKS - 1'b1) begin
        n.blink_cnt = '0;
        n.blink = ~s.blink;
      end else begin
        n.blink_cnt = s.blink_cnt + 1'b1;
      end
    end

    // Activity strobes are stretched so short bursts stay visible
    for (int i = 0; i < ACT_N; i++) begin
      if (act[i]) begin
        n.act_hold[i] = ACT_TICKS;
      end else if (s.tick && s.act_hold[i] != '0) begin
        n.act_hold[i] = s.act_hold[i] - 1'b1;
      end
    end

    // Address editing
    if (!s.loaded) begin
      n.loaded = 1'b1;
      n.addr_hi = digit_clamp(SAVED_ADDR[ADDR_HI_LSB +: 4]);
      n.addr_lo = digit_clamp(SAVED_ADDR[ADDR_LO_LSB +: 4]);
      n.edit_hi = n.addr_hi;
      n.edit_lo = n.addr_lo;
      n.mode = FBAP_NORMAL;
    end else begin
      case (s.mode)
        FBAP_NORMAL: begin
          // Edit copies track the live address, so abandon is a plain jump here
          n.edit_hi = s.addr_hi;
          n.edit_lo = s.addr_lo;
          n.idle_cnt = '0;
          if (bi.double_click) begin
            n.mode = FBAP_EDIT_HI;
          end
        end
        FBAP_EDIT_HI: begin
          if (bi.long_press) begin
            n.mode = FBAP_EDIT_LO;
          end else if (bi.short_press) begin
            n.edit_hi = digit_inc(s.edit_hi);
          end
        end
        FBAP_EDIT_LO: begin
          if (bi.long_press) begin
            n.addr_hi = s.edit_hi;
            n.addr_lo = s.edit_lo;
            n.save = 1'b1;
            n.mode = FBAP_NORMAL;
          end else if (bi.short_press) begin
            n.edit_lo = digit_inc(s.edit_lo);
          end
        end
        default: begin
          n.mode = FBAP_NORMAL;
        end
      endcase

      // Inactivity timeout while editing
      if (s.mode != FBAP_NORMAL) begin
        if (bi.press_start || bi.short_press || bi.long_press) begin
          n.idle_cnt = '0;
        end else if (s.tick) begin
          if (s.idle_cnt >= IDLE_TICKS - 1'b1) begin
            n.mode = FBAP_NORMAL;
            n.idle_cnt = '0;
          end else begin
            n.idle_cnt = s.idle_cnt + 1'b1;
          end
        end
      end
    end

    // Display follows the next mode so both change on one edge
    if (n.mode == FBAP_NORMAL) begin
      n.disp_hi = n.addr_hi;
      n.disp_lo = n.addr_lo;
    end else begin
      n.disp_hi = n.edit_hi;
      n.disp_lo = n.edit_lo;
    end
    n.disp_hi_en = n.loaded && (n.mode == FBAP_EDIT_HI ? n.blink : 1'b1);
    n.disp_lo_en = n.loaded && (n.mode == FBAP_EDIT_LO ? n.blink : 1'b1);

    // Indicators
    n.led_link = (n.act_hold[ACT_LINK] != '0) && n.blink;
    n.led_fault = BUS_FAIL;
    n.led_rx = (n.act_hold[ACT_RX] != '0) && n.blink;
    n.led_tx = (n.act_hold[ACT_TX] != '0) && n.blink;
    n.dir = BUS_TX_EN;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DISP_HI = s.disp_hi;
  assign DISP_LO = s.disp_lo;
  assign DISP_HI_EN = s.disp_hi_en;
  assign DISP_LO_EN = s.disp_lo_en;
  assign STATION_ADDR = {s.addr_hi, s.addr_lo};
  assign ADDR_SAVE = s.save;
  assign LED_LINK = s.led_link;
  assign LED_FAULT = s.led_fault;
  assign LED_RX = s.led_rx;
  assign LED_TX = s.led_tx;
  assign BUS_DIR = s.dir;

endmodule : fbap_panel

`default_nettype wire

// ===== hw/fbap_pkg.sv
package fbap_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 18;
  localparam int TICK_MS = 1;

  // ----------------------------------------------------------------
  // Panel timing, in milliseconds and in ticks
  // ----------------------------------------------------------------
  localparam int LONG_PRESS_MS = 2500;
  localparam int IDLE_TIMEOUT_MS = 10000;
  localparam int DEBOUNCE_MS = 20;
  localparam int DBL_CLICK_MS = 400;
  localparam int BLINK_HALF_MS = 250;
  localparam int ACT_HOLD_MS = 100;
  // Least times round up, longest times round down
  localparam int LONG_TICKS_DEF = (LONG_PRESS_MS + TICK_MS - 1) / TICK_MS;
  localparam int IDLE_TICKS_DEF = (IDLE_TIMEOUT_MS + TICK_MS - 1) / TICK_MS;
  localparam int DEB_TICKS_DEF = (DEBOUNCE_MS + TICK_MS - 1) / TICK_MS;
  localparam int DBL_TICKS_DEF = DBL_CLICK_MS / TICK_MS;
  localparam int BLINK_TICKS_DEF = BLINK_HALF_MS / TICK_MS;
  localparam int ACT_TICKS_DEF = ACT_HOLD_MS / TICK_MS;
  localparam int CNT_W = 14;

  // ----------------------------------------------------------------
  // Address digits
  // ----------------------------------------------------------------
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] DIGIT_RST = 4'h0;
  localparam int ADDR_HI_LSB = 4;
  localparam int ADDR_LO_LSB = 0;

  // ----------------------------------------------------------------
  // Activity indicator indices
  // ----------------------------------------------------------------
  localparam int ACT_N = 3;
  localparam int ACT_LINK = 0;
  localparam int ACT_RX = 1;
  localparam int ACT_TX = 2;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FBAP_NORMAL = 2'b00,
    FBAP_EDIT_HI = 2'b01,
    FBAP_EDIT_LO = 2'b11
  } fbap_mode_t;

  typedef enum logic [1:0] {
    FBAP_B_IDLE = 2'b00,
    FBAP_B_DOWN = 2'b01,
    FBAP_B_LONG = 2'b11,
    FBAP_B_GAP = 2'b10
  } fbap_btn_st_t;

endpackage : fbap_pkg

// ===== hw/fbap_btn_if.sv
`timescale 1ns/1ns
`default_nettype none

interface fbap_btn_if;
  logic tick;
  logic level;
  logic press_start;
  logic short_press;
  logic long_press;
  logic double_click;

  modport ctl (output tick, output level, input press_start, input short_press, input long_press,
               input double_click);
  modport btn (input tick, input level, output press_start, output short_press, output long_press,
               output double_click);
endinterface : fbap_btn_if

`default_nettype wire

// ===== hw/fbap_button.sv
`timescale 1ns/1ns
`default_nettype none

module fbap_button import fbap_pkg::*; #(
  parameter logic [CNT_W-1:0] DEB_TICKS = CNT_W'(DEB_TICKS_DEF),
  parameter logic [CNT_W-1:0] LONG_TICKS = CNT_W'(LONG_TICKS_DEF),
  parameter logic [CNT_W-1:0] DBL_TICKS = CNT_W'(DBL_TICKS_DEF)
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, high
  fbap_btn_if.btn bi // Tick, level and events
);

  typedef struct packed {
    fbap_btn_st_t st;
    logic deb;
    logic [CNT_W-1:0] deb_cnt;
    logic [CNT_W-1:0] cnt;
    logic second;
    logic press_p;
    logic short_p;
    logic long_p;
    logic dbl_p;
  } fbap_btn_state_t;

  fbap_btn_state_t s;
  fbap_btn_state_t n;
  logic press;
  logic release_ev;

  // ----------------------------------------------------------------
  // Debounce and classification
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.press_p = 1'b0;
    n.short_p = 1'b0;
    n.long_p = 1'b0;
    n.dbl_p = 1'b0;
    if (bi.level == s.deb) begin
      n.deb_cnt = '0;
    end else if (bi.tick) begin
      if (s.deb_cnt >= DEB_TICKS - 1'b1) begin
        n.deb = bi.level;
        n.deb_cnt = '0;
      end else begin
        n.deb_cnt = s.deb_cnt + 1'b1;
      end
    end
    press = n.deb & ~s.deb;
    release_ev = ~n.deb & s.deb;
    case (s.st)
      FBAP_B_IDLE: begin
        if (press) begin
          n.st = FBAP_B_DOWN;
          n.cnt = '0;
          n.second = 1'b0;
          n.press_p = 1'b1;
        end
      end
      FBAP_B_DOWN: begin
        if (release_ev) begin
          n.short_p = 1'b1;
          n.cnt = '0;
          if (s.second) begin
            n.dbl_p = 1'b1;
            n.st = FBAP_B_IDLE;
          end else begin
            n.st = FBAP_B_GAP;
            n.second = 1'b1;
          end
        end else if (bi.tick) begin
          if (s.cnt >= LONG_TICKS - 1'b1) begin
            n.long_p = 1'b1;
            n.st = FBAP_B_LONG;
          end else begin
            n.cnt = s.cnt + 1'b1;
          end
        end
      end
      FBAP_B_LONG: begin
        // Release after a long press yields no short press
        if (release_ev) begin
          n.st = FBAP_B_IDLE;
        end
      end
      FBAP_B_GAP: begin
        if (press) begin
          n.st = FBAP_B_DOWN;
          n.cnt = '0;
          n.press_p = 1'b1;
        end else if (bi.tick) begin
          if (s.cnt >= DBL_TICKS - 1'b1) begin
            n.st = FBAP_B_IDLE;
            n.second = 1'b0;
          end else begin
            n.cnt = s.cnt + 1'b1;
          end
        end
      end
      default: begin
        n.st = FBAP_B_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bi.press_start = s.press_p;
  assign bi.short_press = s.short_p;
  assign bi.long_press = s.long_p;
  assign bi.double_click = s.dbl_p;

endmodule : fbap_button

`default_nettype wire

// ===== tb/fbap_panel_props.sv
`timescale 1ns/1ns
`default_nettype none

module fbap_panel_props import fbap_pkg::*; #(
  parameter logic [TICK_W-1:0] TICK_CYC = TICK_W'(TICK_CYC_DEF),
  parameter logic [CNT_W-1:0] ACT_TICKS = CNT_W'(ACT_TICKS_DEF)
) (
  input wire logic CLK_SYS, // Clock
  input wire logic RESET, // Reset, high
  input wire logic LINK_ACTIVE, // Link strobe
  input wire logic SER_RX_ACT, // Rx strobe
  input wire logic SER_TX_ACT, // Tx strobe
  input wire logic BUS_FAIL, // Bus failed
  input wire logic BUS_TX_EN, // Transmitter on
  input wire logic [3:0] DISP_HI, // High digit
  input wire logic [3:0] DISP_LO, // Low digit
  input wire logic DISP_HI_EN, // High lit
  input wire logic DISP_LO_EN, // Low lit
  input wire logic [7:0] STATION_ADDR, // Address
  input wire logic ADDR_SAVE, // Save pulse
  input wire logic LED_LINK, // Link led
  input wire logic LED_RX, // Rx led
  input wire logic LED_TX, // Tx led
  input wire logic LED_FAULT, // Fault led
  input wire logic BUS_DIR // Direction
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Slack covers tick jitter and the output register
  localparam int QUIET_LIM = (int'(ACT_TICKS) + 2) * int'(TICK_CYC) + 4;
  int quiet;
  logic [2:0] rst_hist;

  always_ff @(posedge CLK_SYS) begin
    rst_hist <= {rst_hist[1:0], RESET};
    if (RESET || LINK_ACTIVE || SER_RX_ACT || SER_TX_ACT) begin
      quiet <= 0;
    end else if (quiet < 100000) begin
      quiet <= quiet + 1;
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  AST_RESET_CLEARS: assert property (disable iff (1'b0) RESET |=> STATION_ADDR == 8'h00 && !ADDR_SAVE)
    else $error("outputs not cleared by reset");
  AST_FAULT_FOLLOWS: assert property (!$past(RESET) |-> LED_FAULT == $past(BUS_FAIL))
    else $error("fault indicator wrong");
  AST_DIR_FOLLOWS: assert property (!$past(RESET) |-> BUS_DIR == $past(BUS_TX_EN))
    else $error("direction output wrong");
  AST_SAVE_ONE_CYCLE: assert property (ADDR_SAVE |=> !ADDR_SAVE [*2])
    else $error("save pulse too long");
  AST_SAVE_SHOWS: assert property (ADDR_SAVE |-> DISP_HI_EN && DISP_LO_EN && {DISP_HI, DISP_LO} == STATION_ADDR)
    else $error("display not steady on save");
  AST_DIGITS_DECIMAL: assert property (DISP_HI <= 4'h9 && DISP_LO <= 4'h9)
    else $error("digit out of decimal range");
  AST_ADDR_ONLY_ON_SAVE: assert property (rst_hist == 3'h0 && $changed(STATION_ADDR) |-> ADDR_SAVE)
    else $error("address changed without save");
  AST_ONE_DIGIT_LIT: assert property (rst_hist == 3'h0 |-> DISP_HI_EN || DISP_LO_EN)
    else $error("both digits dark");
  AST_LEDS_DARK_WHEN_QUIET: assert property (quiet > QUIET_LIM |-> !(LED_LINK || LED_RX || LED_TX))
    else $error("activity led lit while quiet");
endmodule : fbap_panel_props

bind fbap_panel fbap_panel_props #(.TICK_CYC(TICK_CYC), .ACT_TICKS(ACT_TICKS)) u_props (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .LINK_ACTIVE(LINK_ACTIVE), .SER_RX_ACT(SER_RX_ACT),
  .SER_TX_ACT(SER_TX_ACT), .BUS_FAIL(BUS_FAIL), .BUS_TX_EN(BUS_TX_EN), .DISP_HI(DISP_HI),
  .DISP_LO(DISP_LO), .DISP_HI_EN(DISP_HI_EN), .DISP_LO_EN(DISP_LO_EN), .STATION_ADDR(STATION_ADDR),
  .ADDR_SAVE(ADDR_SAVE), .LED_LINK(LED_LINK), .LED_RX(LED_RX), .LED_TX(LED_TX),
  .LED_FAULT(LED_FAULT), .BUS_DIR(BUS_DIR));

`default_nettype wire

// ===== tb/fbap_operator.sv
`timescale 1ns/1ns
`default_nettype none

module fbap_operator #(
  parameter int TICK_CYC = 4
) (
  input wire logic clk, // System clock
  output logic button_n // Button pin, low when pressed
);
  initial button_n = 1'b1;

  // Contact bounce on every press, shorter than the debounce window
  task automatic press(input int hold_t, input int gap_t);
    repeat (3) begin
      @(negedge clk) button_n = 1'b0;
      @(negedge clk) button_n = 1'b1;
    end
    @(negedge clk) button_n = 1'b0;
    repeat (hold_t * TICK_CYC) @(negedge clk);
    button_n = 1'b1;
    repeat (gap_t * TICK_CYC) @(negedge clk);
  endtask : press

  task automatic dbl_click;
    press(4, 4);
    press(4, 12);
  endtask : dbl_click
endmodule : fbap_operator

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  typedef struct {int n_hi; int n_lo; logic [7:0] exp;} fbap_row_t;
  fbap_row_t rows [3] = '{'{3, 4, 8'h02}, '{0, 1, 8'h03}, '{9, 9, 8'h92}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] act = 3'h0;
  logic fail = 1'b0;
  logic txen = 1'b0;
  logic [7:0] saved = 8'h78;
  logic btn_n, hi_en, lo_en, save, l_link, l_fault, l_rx, l_tx, dir;
  logic [3:0] d_hi, d_lo;
  logic [7:0] addr;
  logic [2:0] leds, lit_seen, dark_seen;
  int error_cnt = 0;
  int tests_run = 0;
  int saves = 0;
  int cyc = 0;
  int hi_off, lo_off, s0;

  always #2 clk = ~clk;
  assign leds = {l_tx, l_rx, l_link};

  // Tick is 4 cycles; idle and double-click windows keep their real tick counts
  fbap_panel #(.TICK_CYC(18'h4), .LONG_TICKS(14'h14), .DEB_TICKS(14'h2),
    .BLINK_TICKS(14'h3), .ACT_TICKS(14'h5)) dut (
    .CLK_SYS(clk), .RESET(rst), .BUTTON_N(btn_n), .LINK_ACTIVE(act[0]), .BUS_FAIL(fail),
    .SER_RX_ACT(act[1]), .SER_TX_ACT(act[2]), .BUS_TX_EN(txen), .SAVED_ADDR(saved),
    .DISP_HI(d_hi), .DISP_LO(d_lo), .DISP_HI_EN(hi_en), .DISP_LO_EN(lo_en), .STATION_ADDR(addr),
    .ADDR_SAVE(save), .LED_LINK(l_link), .LED_FAULT(l_fault), .LED_RX(l_rx), .LED_TX(l_tx),
    .BUS_DIR(dir));

  fbap_operator op (.clk(clk), .button_n(btn_n));

  always @(posedge clk) begin
    cyc++;
    if (save === 1'b1) saves++;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic watch(input int n);
    hi_off = 0;
    lo_off = 0;
    lit_seen = 3'h0;
    dark_seen = 3'h0;
    repeat (n) @(negedge clk) begin
      if (hi_en !== 1'b1) hi_off++;
      if (lo_en !== 1'b1) lo_off++;
      lit_seen |= leds;
      dark_seen |= ~leds;
    end
  endtask : watch

  task automatic normal_shows(input logic [7:0] exp);
    check("station", addr, exp);
    check("display", {d_hi, d_lo}, exp);
    check("steady", {6'h0, hi_en, lo_en}, 8'h03);
  endtask : normal_shows

  task automatic do_reset;
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    check("reset addr", addr, 8'h00);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask : do_reset

  task automatic tally_and_finish;
    $display("%0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    normal_shows(8'h78);
    foreach (rows[i]) begin
      op.dbl_click();
      watch(32);
      check("hi blinks", 8'(hi_off > 0), 8'h01);
      check("lo steady", 8'(lo_off), 8'h00);
      repeat (rows[i].n_hi) op.press(6, 6);
      check("hi digit", {4'h0, d_hi}, {4'h0, rows[i].exp[7:4]});
      op.press(30, 6);
      watch(32);
      check("hi steady", 8'(hi_off), 8'h00);
      check("lo blinks", 8'(lo_off > 0), 8'h01);
      check("hi kept", {4'h0, d_hi}, {4'h0, rows[i].exp[7:4]});
      s0 = saves;
      repeat (rows[i].n_lo) op.press(6, 6);
      op.press(30, 20);
      check("save count", 8'(saves - s0), 8'h01);
      normal_shows(rows[i].exp);
      $display("edit row %0d done", i);
    end
    s0 = saves;
    op.dbl_click();
    op.press(6, 6);
    op.press(6, 6);
    // Full idle window is 10000 ticks, about 40000 cycles
    repeat (35000) @(negedge clk);
    watch(32);
    check("still editing", 8'(hi_off > 0), 8'h01);
    repeat (5400) @(negedge clk);
    normal_shows(8'h92);
    op.press(6, 20);
    op.press(30, 20);
    normal_shows(8'h92);
    check("no save", 8'(saves - s0), 8'h00);
    $display("timeout test done");
    for (int k = 0; k < 3; k++) begin
      @(negedge clk) act = 3'(1 << k);
      watch(48);
      check("led lit", {5'h0, lit_seen}, 8'(1 << k));
      check("led blinks", {7'h0, dark_seen[k]}, 8'h01);
      act = 3'h0;
      repeat (40) @(negedge clk);
      check("led off", {5'h0, leds}, 8'h00);
    end
    $display("indicator test done");
    @(negedge clk) fail = 1'b1;
    txen = 1'b1;
    @(negedge clk);
    check("fault dir on", {6'h0, l_fault, dir}, 8'h03);
    fail = 1'b0;
    txen = 1'b0;
    @(negedge clk);
    check("fault dir off", {6'h0, l_fault, dir}, 8'h00);
    $display("fault test done");
    saved = 8'h3c;
    op.dbl_click();
    do_reset();
    normal_shows(8'h30);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
